// [rtl/pser_pkg.sv]
package pser_pkg;

  // ***********************************************************
  // register offsets on the management port
  // ***********************************************************
  localparam logic [4:0] ADDR_STRAP_ONE = 5'h09;
  localparam logic [4:0] ADDR_STRAP_THREE = 5'h0b;
  localparam logic [4:0] ADDR_ACC_CTRL = 5'h0d;
  localparam logic [4:0] ADDR_WINDOW = 5'h0e;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int CFG_DONE_BIT = 15;
  localparam int STRAP3_W = 7;
  localparam int POL_SWAP_BIT = 6;
  localparam int PAIR_EXCH_BIT = 5;
  localparam int BYPASS_BIT = 4;
  localparam int FLD_RX_ERR_BIT = 3;
  localparam int FLD_MLT3_BIT = 2;
  localparam int FLD_SNR_BIT = 1;
  localparam int FLD_ENERGY_BIT = 0;
  localparam int FUNC_HI = 15;
  localparam int FUNC_LO = 14;
  localparam int DEV_SEL_HI = 4;
  localparam logic [4:0] DEV_SEL_EXT = 5'h1f;

  // ***********************************************************
  // values after reset
  // ***********************************************************
  localparam logic [6:0] STRAP3_RST = 7'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;

  // ***********************************************************
  // timing and thresholds
  // ***********************************************************
  localparam int CLK_MHZ = 250;
  localparam int WINDOW_US = 10;
  localparam int WINDOW_CYCLES = WINDOW_US * CLK_MHZ;
  localparam int THRESH_RX_ERR = 32;
  localparam int THRESH_MLT3 = 20;
  localparam int THRESH_SNR = 20;

  typedef enum logic [1:0] {
    FUNC_ADDRESS = 2'b00,
    FUNC_DATA = 2'b01,
    FUNC_POST_RW = 2'b10,
    FUNC_POST_WR = 2'b11
  } pser_func_t;

endpackage

// [rtl/pser_fld_if.sv]
`timescale 1ns/10ps
interface pser_fld_if;
  logic enable;
  logic event_in;
  logic window_start;
  logic hit;

  modport counter (
    input enable,
    input event_in,
    input window_start,
    output hit
  );

  modport ctrl (
    output enable,
    output event_in,
    output window_start,
    input hit
  );
endinterface

// [rtl/pser_sync.sv]
`timescale 1ns/10ps
module pser_sync (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic d,
  output logic q
);

  typedef struct packed {
    logic ff1;
    logic ff2;
  } pser_sync_st_t;

  pser_sync_st_t st;
  pser_sync_st_t next_st;

  always_comb
  begin
    next_st.ff1 = d;
    next_st.ff2 = st.ff1;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign q = st.ff2;

endmodule // pser_sync

// [rtl/pser_window_counter.sv]
`timescale 1ns/10ps
module pser_window_counter #(
  parameter int THRESH = 20
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  pser_fld_if.counter port
);

  localparam int CNT_W = $clog2(THRESH + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(THRESH - 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic hit;
  } pser_cnt_st_t;

  pser_cnt_st_t st;
  pser_cnt_st_t next_st;

  // count restarts each interval; hit holds to the interval end
  always_comb
  begin
    next_st = st;
    if (!port.enable)
    begin
      next_st.cnt = '0;
      next_st.hit = 1'b0;
    end
    else if (port.window_start)
    begin
      next_st.cnt = port.event_in ? CNT_W'(1) : '0;
      next_st.hit = 1'b0;
    end
    else if (port.event_in && !st.hit)
    begin
      next_st.cnt = st.cnt + 1'b1;
      next_st.hit = (st.cnt == CNT_LAST);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign port.hit = st.hit;

  property p_thresh_hit;
    @(posedge ref_clk) disable iff (!arst_n)
    (port.enable && port.event_in && !port.window_start && !st.hit && st.cnt == CNT_LAST)
    |=> st.hit;
  endproperty
  a_thresh_hit: assert property (p_thresh_hit)
    else $error("threshold count did not raise hit");

  property p_no_early_hit;
    @(posedge ref_clk) disable iff (!arst_n)
    (port.window_start || !port.enable) |=> !st.hit;
  endproperty
  a_no_early_hit: assert property (p_no_early_hit)
    else $error("hit raised at interval start");

endmodule // pser_window_counter

// [rtl/pser_top.sv]
`timescale 1ns/10ps
// What this block does
// - strap three bits 15..7 ignore writes and read as zero.
// - config-done write makes an internal pulse that latches strap values.
// - strap bit 6 inverts polarity of both twisted pairs.
// - strap bit 5 swaps transmit and receive pair roles.
// - port mirror enabled only when bits 5 and 6 both set.
// - strap bit 4 bypasses 4b/5b coding, raw 5-bit symbols.
// - in bypass, tx bit 4 from test-data pin, rx bit 4 on error pin.
// - bit 3 drops link at 32 receive errors within 10 us.
// - bit 2 drops link at 20 mlt-3 violations within 10 us.
// - bit 1 drops link at 20 low snr crossings within 10 us.
// - bit 0 drops link on energy loss, within about 10 us.
// - link drop is the or of all enabled triggers.
// - extended registers reached only through 0x000d and 0x000e.
// - function 00 makes a window write load the pointer.
// - function 01 accesses pointed register, pointer unchanged.
// - function 10 accesses pointed register, pointer increments after each.
// - function 11 increments the pointer after writes only.
// - window accesses with device address other than 11111 are ignored.
// - function field in bits 15..14, device address in bits 4..0.
module pser_top #(
  parameter int EXT_DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic rx_err_event,
  input wire logic mlt3_violation,
  input wire logic low_snr_cross,
  input wire logic energy_loss,
  input wire logic tdi_pin,
  input wire logic rx_sym4,
  input wire logic rx_err_in,
  output logic polarity_swap,
  output logic pair_role_exchange,
  output logic port_mirror,
  output logic symbol_code_bypass,
  output logic tx_symbol_bit4,
  output logic receive_error_pin,
  output logic link_drop
);

  // ***********************************************************
  // local sizes
  // ***********************************************************
  localparam int EXT_AW = $clog2(EXT_DEPTH);
  localparam int WIN_W = $clog2(pser_pkg::WINDOW_CYCLES);
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(pser_pkg::WINDOW_CYCLES - 1);
  localparam int PAD_W = 16 - pser_pkg::STRAP3_W;

  typedef struct packed {
    logic [6:0] strap3;
    logic cfg_done;
    logic cfg_pulse;
    logic [6:0] active;
    pser_pkg::pser_func_t func;
    logic [4:0] dev_sel;
    logic [15:0] ptr;
    logic [EXT_DEPTH-1:0][15:0] ext;
    logic [WIN_W-1:0] win;
    logic win_start;
    logic [15:0] rd_data;
    logic rd_valid;
    logic pol_swap;
    logic pair_exch;
    logic mirror;
    logic bypass;
    logic txd4;
    logic rx_err_pin;
    logic link_drop;
  } pser_top_st_t;

  pser_top_st_t st;
  pser_top_st_t next_st;
  logic tdi_sync;
  logic ext_ok;
  logic win_wr;
  logic win_rd;
  logic [EXT_AW-1:0] idx;

  pser_fld_if fld_rx_err ();
  pser_fld_if fld_mlt3 ();
  pser_fld_if fld_snr ();

  // ***********************************************************
  // pin synchroniser and event counters
  // ***********************************************************
  pser_sync u_tdi_sync (
    .ref_clk (ref_clk),
    .arst_n (arst_n),
    .d (tdi_pin),
    .q (tdi_sync)
  );

  assign fld_rx_err.enable = st.active[pser_pkg::FLD_RX_ERR_BIT];
  assign fld_rx_err.event_in = rx_err_event;
  assign fld_rx_err.window_start = st.win_start;
  assign fld_mlt3.enable = st.active[pser_pkg::FLD_MLT3_BIT];
  assign fld_mlt3.event_in = mlt3_violation;
  assign fld_mlt3.window_start = st.win_start;
  assign fld_snr.enable = st.active[pser_pkg::FLD_SNR_BIT];
  assign fld_snr.event_in = low_snr_cross;
  assign fld_snr.window_start = st.win_start;

  pser_window_counter #(.THRESH(pser_pkg::THRESH_RX_ERR)) u_cnt_rx_err (
    .ref_clk (ref_clk),
    .arst_n (arst_n),
    .port (fld_rx_err)
  );

  pser_window_counter #(.THRESH(pser_pkg::THRESH_MLT3)) u_cnt_mlt3 (
    .ref_clk (ref_clk),
    .arst_n (arst_n),
    .port (fld_mlt3)
  );

  pser_window_counter #(.THRESH(pser_pkg::THRESH_SNR)) u_cnt_snr (
    .ref_clk (ref_clk),
    .arst_n (arst_n),
    .port (fld_snr)
  );

  // ***********************************************************
  // register decode and state update
  // ***********************************************************
  assign ext_ok = (st.dev_sel == pser_pkg::DEV_SEL_EXT);
  assign win_wr = reg_wr && (reg_addr == pser_pkg::ADDR_WINDOW) && ext_ok;
  assign win_rd = reg_rd && (reg_addr == pser_pkg::ADDR_WINDOW) && ext_ok;
  assign idx = st.ptr[EXT_AW-1:0];

  always_comb
  begin
    next_st = st;
    next_st.cfg_pulse = 1'b0;
    next_st.rd_valid = 1'b0;
    next_st.win_start = 1'b0;
    // free-running 10 us interval shared by all counters
    if (st.win == WIN_LAST)
    begin
      next_st.win = '0;
      next_st.win_start = 1'b1;
    end
    else
      next_st.win = st.win + 1'b1;
    if (reg_wr)
    begin
      case (reg_addr)
        pser_pkg::ADDR_STRAP_ONE:
          if (reg_wdata[pser_pkg::CFG_DONE_BIT])
          begin
            next_st.cfg_done = 1'b1;
            next_st.cfg_pulse = 1'b1;
          end
        pser_pkg::ADDR_STRAP_THREE:
          next_st.strap3 = reg_wdata[pser_pkg::STRAP3_W-1:0];
        pser_pkg::ADDR_ACC_CTRL:
        begin
          next_st.func = pser_pkg::pser_func_t'(reg_wdata[pser_pkg::FUNC_HI:pser_pkg::FUNC_LO]);
          next_st.dev_sel = reg_wdata[pser_pkg::DEV_SEL_HI:0];
        end
        default:
        begin
        end
      endcase
    end
    if (win_wr)
    begin
      if (st.func == pser_pkg::FUNC_ADDRESS)
        next_st.ptr = reg_wdata;
      else
      begin
        next_st.ext[idx] = reg_wdata;
        if (st.func != pser_pkg::FUNC_DATA)
          next_st.ptr = st.ptr + 16'h0001;
      end
    end
    if (reg_rd)
    begin
      next_st.rd_valid = 1'b1;
      next_st.rd_data = '0;
      case (reg_addr)
        pser_pkg::ADDR_STRAP_ONE:
          next_st.rd_data[pser_pkg::CFG_DONE_BIT] = st.cfg_done;
        pser_pkg::ADDR_STRAP_THREE:
          next_st.rd_data = {{PAD_W{1'b0}}, st.strap3};
        pser_pkg::ADDR_ACC_CTRL:
          next_st.rd_data = {st.func, 9'h000, st.dev_sel};
        pser_pkg::ADDR_WINDOW:
          if (ext_ok)
            next_st.rd_data = (st.func == pser_pkg::FUNC_ADDRESS) ? st.ptr : st.ext[idx];
        default:
        begin
        end
      endcase
    end
    // a read in the same cycle as a window write never adds a second step
    if (win_rd && !win_wr && st.func == pser_pkg::FUNC_POST_RW)
      next_st.ptr = st.ptr + 16'h0001;
    if (st.cfg_pulse)
      next_st.active = st.strap3;
    next_st.pol_swap = st.active[pser_pkg::POL_SWAP_BIT];
    next_st.pair_exch = st.active[pser_pkg::PAIR_EXCH_BIT];
    next_st.mirror = st.active[pser_pkg::POL_SWAP_BIT] && st.active[pser_pkg::PAIR_EXCH_BIT];
    next_st.bypass = st.active[pser_pkg::BYPASS_BIT];
    next_st.txd4 = st.active[pser_pkg::BYPASS_BIT] ? tdi_sync : 1'b0;
    next_st.rx_err_pin = st.active[pser_pkg::BYPASS_BIT] ? rx_sym4 : rx_err_in;
    next_st.link_drop = fld_rx_err.hit || fld_mlt3.hit || fld_snr.hit ||
      (st.active[pser_pkg::FLD_ENERGY_BIT] && energy_loss);
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.strap3 <= pser_pkg::STRAP3_RST;
      st.ptr <= pser_pkg::PTR_RST;
    end
    else
      st <= next_st;
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign reg_rdata = st.rd_data;
  assign reg_rvalid = st.rd_valid;
  assign polarity_swap = st.pol_swap;
  assign pair_role_exchange = st.pair_exch;
  assign port_mirror = st.mirror;
  assign symbol_code_bypass = st.bypass;
  assign tx_symbol_bit4 = st.txd4;
  assign receive_error_pin = st.rx_err_pin;
  assign link_drop = st.link_drop;

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_cfg_write;
    reg_wr && reg_addr == pser_pkg::ADDR_STRAP_ONE && reg_wdata[pser_pkg::CFG_DONE_BIT];
  endsequence

  sequence s_cfg_latched;
    st.cfg_pulse ##1 (st.active == $past(st.strap3));
  endsequence

  property p_strap_reserved;
    (reg_rd && reg_addr == pser_pkg::ADDR_STRAP_THREE) |=> reg_rvalid && reg_rdata[15:7] == 9'h000;
  endproperty
  a_strap_reserved: assert property (p_strap_reserved)
    else $error("strap three reserved bits not zero");

  property p_cfg_latch;
    s_cfg_write |=> s_cfg_latched;
  endproperty
  a_cfg_latch: assert property (p_cfg_latch)
    else $error("config done did not latch straps");

  property p_pol_follows;
    s_cfg_write ##1 st.cfg_pulse |=> ##1 (polarity_swap == st.active[pser_pkg::POL_SWAP_BIT]);
  endproperty
  a_pol_follows: assert property (p_pol_follows)
    else $error("polarity output does not follow latched strap");

  property p_mirror;
    port_mirror == (polarity_swap && pair_role_exchange);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("port mirror without both swap bits");

  property p_bypass_rx;
    (st.active[pser_pkg::BYPASS_BIT] && $stable(st.active)) |=> receive_error_pin == $past(rx_sym4);
  endproperty
  a_bypass_rx: assert property (p_bypass_rx)
    else $error("bypass rx bit not on error pin");

  property p_energy_drop;
    (st.active[pser_pkg::FLD_ENERGY_BIT] && energy_loss) |=> link_drop;
  endproperty
  a_energy_drop: assert property (p_energy_drop)
    else $error("energy loss did not drop link");

  property p_quiet;
    (st.active[3:0] == 4'h0 && $past(st.active[3:0]) == 4'h0) |=> !link_drop;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("link dropped with all triggers disabled");

  property p_ptr_load;
    (win_wr && st.func == pser_pkg::FUNC_ADDRESS) |=> st.ptr == $past(reg_wdata);
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer not loaded in address function");

  property p_ptr_hold;
    ((win_wr || win_rd) && st.func == pser_pkg::FUNC_DATA) |=> $stable(st.ptr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("pointer moved in data function");

  property p_ptr_inc_rw;
    ((win_wr || win_rd) && st.func == pser_pkg::FUNC_POST_RW) |=> st.ptr == $past(st.ptr) + 16'h0001;
  endproperty
  a_ptr_inc_rw: assert property (p_ptr_inc_rw)
    else $error("pointer did not step after access");

  property p_ptr_wr_only;
    (win_rd && !win_wr && st.func == pser_pkg::FUNC_POST_WR) |=> $stable(st.ptr);
  endproperty
  a_ptr_wr_only: assert property (p_ptr_wr_only)
    else $error("pointer stepped on read in write-only mode");

  property p_bad_target_device_address_field;
    (reg_wr && reg_addr == pser_pkg::ADDR_WINDOW && !ext_ok) |=> $stable(st.ptr) && $stable(st.ext);
  endproperty
  a_bad_target_device_address_field: assert property (p_bad_target_device_address_field)
    else $error("window write taken with wrong device address");

endmodule // pser_top

// [test/pser_host_model.sv]
`timescale 1ns/10ps
module pser_host_model (
  input wire logic ref_clk,
  output logic [4:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // ***********************************************************
  // management host on the strobe port
  // ***********************************************************
  initial
  begin
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // released address and data show the inverse, never the stale value
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
  begin
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  end
  endtask

  task automatic rd(input logic [4:0] a);
  begin
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  end
  endtask
endmodule // pser_host_model

// [test/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] ev = 3'h0;
  logic energy_loss = 1'b0;
  logic tdi_pin = 1'b0;
  logic rx_sym4 = 1'b0;
  logic rx_err_in = 1'b0;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic polarity_swap;
  logic pair_role_exchange;
  logic port_mirror;
  logic symbol_code_bypass;
  logic tx_symbol_bit4;
  logic receive_error_pin;
  logic link_drop;
  int num_errors = 0;
  int cmp_count = 0;
  logic [15:0] exp_q[$];
  logic [31:0] rng = 32'h0000004f;
  logic [15:0] v[3];
  logic [15:0] x;
  logic s;
  logic [7:0] straps[6] = '{8'h40, 8'h20, 8'h60, 8'h10, 8'h70, 8'h00};
  int th[3] = '{32, 20, 20};

  always #2 ref_clk = ~ref_clk;

  pser_top #(.EXT_DEPTH(32)) dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .rx_err_event(ev[0]), .mlt3_violation(ev[1]), .low_snr_cross(ev[2]),
    .energy_loss(energy_loss), .tdi_pin(tdi_pin), .rx_sym4(rx_sym4), .rx_err_in(rx_err_in),
    .polarity_swap(polarity_swap), .pair_role_exchange(pair_role_exchange),
    .port_mirror(port_mirror), .symbol_code_bypass(symbol_code_bypass),
    .tx_symbol_bit4(tx_symbol_bit4), .receive_error_pin(receive_error_pin),
    .link_drop(link_drop)
  );

  pser_host_model host (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd)
  );

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic [15:0] nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[15:0];
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
  begin
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask

  task automatic rd_exp(input logic [4:0] a, input logic [15:0] e);
  begin
    exp_q.push_back(e);
    host.rd(a);
  end
  endtask

  // strap values only reach the outputs after a config-done write
  task automatic cfg(input logic [15:0] d);
  begin
    host.wr(5'h0b, d);
    rd_exp(5'h0b, {9'h000, d[6:0]});
    host.wr(5'h09, 16'h8000);
    repeat (4) @(posedge ref_clk);
    #1;
  end
  endtask

  // keeps pulsing one event source and notes any link drop on the way
  task automatic burst(input int idx, input int n, output logic seen);
  begin
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge ref_clk);
      ev <= 3'h1 << idx;
      #1 seen |= link_drop;
    end
    @(posedge ref_clk);
    ev <= 3'h0;
    repeat (3)
    begin
      @(posedge ref_clk);
      #1 seen |= link_drop;
    end
  end
  endtask

  task automatic give_verdict();
  begin
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  // ***********************************************************
  // read answers against the oldest note
  // ***********************************************************
  always @(posedge ref_clk)
  begin
    if (reg_rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk({15'h0, reg_rvalid}, 16'h0000);
      else
        chk(reg_rdata, exp_q.pop_front());
    end
  end

  initial
  begin
    #(60000 * 4);
    num_errors++;
    give_verdict();
  end

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial
  begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd_exp(5'h0b, 16'h0000);
    rd_exp(5'h0d, 16'h0000);
    host.wr(5'h0d, 16'h001f);
    rd_exp(5'h0e, 16'h0000);
    foreach (straps[i])
    begin
      x = nxt();
      cfg({x[15:7], straps[i][6:0]});
      chk({15'h0, polarity_swap}, {15'h0, straps[i][6]});
      chk({15'h0, pair_role_exchange}, {15'h0, straps[i][5]});
      chk({15'h0, port_mirror}, {15'h0, straps[i][6] & straps[i][5]});
      chk({15'h0, symbol_code_bypass}, {15'h0, straps[i][4]});
      @(posedge ref_clk);
      tdi_pin <= x[0];
      rx_sym4 <= x[1];
      rx_err_in <= x[2];
      repeat (5) @(posedge ref_clk);
      #1;
      chk({15'h0, tx_symbol_bit4}, {15'h0, straps[i][4] & x[0]});
      chk({15'h0, receive_error_pin}, {15'h0, straps[i][4] ? x[1] : x[2]});
    end
    rd_exp(5'h09, 16'h8000);
    foreach (v[i])
      v[i] = nxt();
    host.wr(5'h0d, 16'h001f);
    host.wr(5'h0e, 16'h0005);
    rd_exp(5'h0e, 16'h0005);
    host.wr(5'h0d, 16'h401f);
    host.wr(5'h0e, v[0]);
    rd_exp(5'h0e, v[0]);
    rd_exp(5'h0e, v[0]);
    host.wr(5'h0d, 16'h001f);
    rd_exp(5'h0e, 16'h0005);
    host.wr(5'h0d, 16'h801f);
    foreach (v[i])
      host.wr(5'h0e, v[i]);
    host.wr(5'h0d, 16'h001f);
    rd_exp(5'h0e, 16'h0008);
    host.wr(5'h0e, 16'h0005);
    host.wr(5'h0d, 16'h801f);
    foreach (v[i])
      rd_exp(5'h0e, v[i]);
    host.wr(5'h0d, 16'h001f);
    rd_exp(5'h0e, 16'h0008);
    host.wr(5'h0e, 16'h0005);
    host.wr(5'h0d, 16'hc01f);
    rd_exp(5'h0e, v[0]);
    rd_exp(5'h0e, v[0]);
    host.wr(5'h0e, nxt());
    rd_exp(5'h0e, v[1]);
    host.wr(5'h0d, 16'h401e);
    host.wr(5'h0e, nxt());
    rd_exp(5'h0e, 16'h0000);
    host.wr(5'h0d, 16'h001e);
    host.wr(5'h0e, 16'h0007);
    host.wr(5'h0d, 16'h401f);
    rd_exp(5'h0e, v[1]);
    host.wr(5'h0d, 16'hffff);
    rd_exp(5'h0d, 16'hc01f);
    rd_exp(5'h1f, 16'h0000);
    energy_loss <= 1'b1;
    burst(1, 64, s);
    chk({15'h0, s}, 16'h0000);
    energy_loss <= 1'b0;
    cfg(16'h000f);
    energy_loss <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk({15'h0, link_drop}, 16'h0001);
    energy_loss <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk({15'h0, link_drop}, 16'h0000);
    foreach (th[i])
    begin
      repeat (2600) @(posedge ref_clk);
      burst(i, th[i] - 1, s);
      chk({15'h0, s}, 16'h0000);
      burst(i, 2 * th[i], s);
      chk({15'h0, s}, 16'h0001);
    end
    repeat (4) @(posedge ref_clk);
    give_verdict();
  end
endmodule // tb_top
